// ===== logic/pbs_pkg.sv
// Purpose: Shared constants for the pipelined burst SRAM core
// Assumes: Single 25 MHz clock
// Notes:   Lane word is {parity bit, eight data bits}
package pbs_pkg;
  localparam int ADDR_W        = 18;
  localparam int LANES         = 2;
  localparam int BYTE_W        = 8;
  localparam int LANE_W        = BYTE_W + 1;
  localparam int DATA_W        = LANES * BYTE_W;
  localparam int WORD_W        = LANES * LANE_W;
  localparam int BEAT_W        = 2;
  localparam int CLK_PERIOD_NS = 40;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;

  typedef enum logic [1:0] {
    PBS_AWAKE,
    PBS_ENTERING,
    PBS_ASLEEP,
    PBS_LEAVING
  } pbs_sleep_t;
endpackage : pbs_pkg

// ===== logic/pbs_mem_if.sv
// Purpose: Array access port between control and storage
// Assumes: Combinational read, write on clock edge
// Notes:   Lane write selects are active low
`timescale 1ns/1ps
interface pbs_mem_if;
  import pbs_pkg::*;
  logic                wr_en;
  logic [ADDR_W-1:0]   wr_addr;
  logic [LANES-1:0]    wr_lane_n;
  logic [WORD_W-1:0]   wr_word;
  logic [ADDR_W-1:0]   rd_addr;
  logic [WORD_W-1:0]   rd_word;

  modport ctrl  (output wr_en, wr_addr, wr_lane_n, wr_word, rd_addr, input rd_word);
  modport array (input wr_en, wr_addr, wr_lane_n, wr_word, rd_addr, output rd_word);
endinterface : pbs_mem_if

// ===== logic/pbs_burst_seq.sv
// Purpose: Low address bits of a burst beat
// Assumes: Two-bit beat count
// Notes:   Linear adds, interleaved XORs
`timescale 1ns/1ps
module pbs_burst_seq
  import pbs_pkg::*;
(
  // Burst position
  input  wire logic [BEAT_W-1:0] start_low,
  input  wire logic [BEAT_W-1:0] beat,
  input  wire logic              interleave,
  // Resulting low bits
  output      logic [BEAT_W-1:0] beat_low
);
  always_comb begin
    if (interleave) begin
      beat_low = start_low ^ beat;
    end else begin
      beat_low = BEAT_W'(start_low + beat);
    end
  end
endmodule : pbs_burst_seq

// ===== logic/pbs_array.sv
// Purpose: Storage array with per-lane writes
// Assumes: Write port driven only on qualified edges
// Notes:   No reset, contents survive sleep
`timescale 1ns/1ps
module pbs_array #(
  parameter int AW = pbs_pkg::ADDR_W,
  parameter int NL = pbs_pkg::LANES,
  parameter int LW = pbs_pkg::LANE_W
) (
  // Clock
  input  wire logic core_clk,
  // Access port
  pbs_mem_if.array  mem
);
  logic [NL*LW-1:0] store [2**AW];

  assign mem.rd_word = store[mem.rd_addr];

  // ----------------------------------------
  // Lane writes
  // ----------------------------------------
  // One process: the whole array has a single writer
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NL; i++) begin
      if (mem.wr_en && !mem.wr_lane_n[i]) begin
        store[mem.wr_addr][i*LW +: LW] <= mem.wr_word[i*LW +: LW];
      end
    end
  end
endmodule : pbs_array

// ===== logic/pbs_core.sv
// Purpose: Pipelined burst SRAM core, device side
// Assumes: All inputs synchronous to core_clk
// Notes:   Output enable is sampled, so drive follows it one clock late
//
// Summary of operation
// - Qualifier high freezes all pipeline state, not sleep or drive enables
// - Inputs registered, read data through output register
// - Load address when selected, qualified, load
// - Read on load with write strobe high
// - Read data after next edge, driven if enabled
// - New command accepted right after a read
// - Deselect floats outputs after following edge
// - Two-bit burst counter wraps after four
// - Strap low linear, strap high interleaved
// - Advance increments counter, ignoring selects, strobe
// - Access type fixed for the whole burst
// - Write on load with strobe low, latch lanes
// - Float data and parity edge after write
// - Write data captured second edge after command
// - Only selected lanes with parity updated
// - Sleep keeps contents, two cycles each way
// - Accesses pending at sleep entry discarded
// - Interleaved low bits are start XOR beat
// - Linear low bits are start plus beat
// - Outputs float in write, resume, deselect
// - Powers up deselected with outputs floating
`timescale 1ns/1ps
module pbs_core
  import pbs_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  // Command
  input  wire logic                 clock_qualifier_n,
  input  wire logic                 chip_select_1_n,
  input  wire logic                 chip_select_2,
  input  wire logic                 chip_select_3_n,
  input  wire logic                 advance_or_load,
  input  wire logic                 write_enable_n,
  input  wire logic [LANES-1:0]     byte_lane_write_n,
  input  wire logic [ADDR_W-1:0]    address,
  // Straps and async controls
  input  wire logic                 burst_order,
  input  wire logic                 output_enable_n,
  input  wire logic                 sleep_request,
  // Data lines
  input  wire logic [DATA_W-1:0]    data_in,
  input  wire logic [LANES-1:0]     parity_lines_in,
  output      logic [DATA_W-1:0]    data_out,
  output      logic                 data_oe_n,
  output      logic [LANES-1:0]     parity_lines_out,
  output      logic                 parity_lines_oe_n,
  // Status
  output      logic                 sleep_active
);
  import pbs_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic                rst_meta;
  logic                rst_n;
  pbs_sleep_t          sleep_state;
  pbs_sleep_t          next_sleep_state;
  logic                awake;
  logic                all_sel;
  logic                en;
  logic                load;
  logic                adv;
  logic                burst_live;
  logic                burst_write;
  logic [ADDR_W-1:0]   burst_base;
  logic [BEAT_W-1:0]   burst_beat;
  logic [BEAT_W-1:0]   next_beat;
  logic [BEAT_W-1:0]   seq_low;
  logic                a_valid;
  logic                a_write;
  logic [ADDR_W-1:0]   a_addr;
  logic [LANES-1:0]    a_lane_n;
  logic                b_write;
  logic [ADDR_W-1:0]   b_addr;
  logic [LANES-1:0]    b_lane_n;
  logic                out_valid;
  logic                next_out_valid;
  logic [WORD_W-1:0]   out_word;

  pbs_mem_if mem_bus ();

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // Sleep sequencing
  // ----------------------------------------
  // Runs free of the qualifier: sleep is asynchronous to it
  always_comb begin
    next_sleep_state = sleep_state;
    unique case (sleep_state)
      PBS_AWAKE:    if (sleep_request)  next_sleep_state = PBS_ENTERING;
      PBS_ENTERING: next_sleep_state = sleep_request ? PBS_ASLEEP : PBS_AWAKE;
      PBS_ASLEEP:   if (!sleep_request) next_sleep_state = PBS_LEAVING;
      PBS_LEAVING:  next_sleep_state = sleep_request ? PBS_ASLEEP : PBS_AWAKE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_state  <= PBS_AWAKE;
      sleep_active <= 1'b0;
    end else begin
      sleep_state  <= next_sleep_state;
      sleep_active <= (next_sleep_state != PBS_AWAKE);
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign awake   = (sleep_state == PBS_AWAKE);
  assign all_sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign en      = !clock_qualifier_n && awake;
  assign load    = en && !advance_or_load;
  assign adv     = en && advance_or_load;
  assign next_beat = BEAT_W'(burst_beat + BEAT_STEP);

  pbs_burst_seq u_seq (
    .start_low  (burst_base[BEAT_W-1:0]),
    .beat       (next_beat),
    .interleave (burst_order),
    .beat_low   (seq_low)
  );

  // ----------------------------------------
  // Burst tracking
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_live  <= 1'b0;
      burst_write <= 1'b0;
      burst_base  <= '0;
      burst_beat  <= BEAT_FIRST;
    end else if (!awake) begin
      burst_live  <= 1'b0;
    end else if (load) begin
      burst_live  <= all_sel;
      burst_write <= !write_enable_n;
      burst_base  <= address;
      burst_beat  <= BEAT_FIRST;
    end else if (adv && burst_live) begin
      burst_beat  <= next_beat;
    end
  end

  // ----------------------------------------
  // Address stage
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_valid  <= 1'b0;
      a_write  <= 1'b0;
      a_addr   <= '0;
      a_lane_n <= '1;
    end else if (!awake) begin
      a_valid  <= 1'b0;
    end else if (load) begin
      a_valid  <= all_sel;
      a_write  <= !write_enable_n;
      a_addr   <= address;
      a_lane_n <= byte_lane_write_n;
    end else if (adv) begin
      a_valid  <= burst_live;
      a_write  <= burst_write;
      a_addr   <= {burst_base[ADDR_W-1:BEAT_W], seq_low};
      a_lane_n <= byte_lane_write_n;
    end
  end

  // ----------------------------------------
  // Write data stage
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      b_write  <= 1'b0;
      b_addr   <= '0;
      b_lane_n <= '1;
    end else if (!awake) begin
      b_write  <= 1'b0;
    end else if (en) begin
      b_write  <= a_valid && a_write;
      b_addr   <= a_addr;
      b_lane_n <= a_lane_n;
    end
  end

  // Data is taken at the second qualified edge after the command
  assign mem_bus.wr_en     = en && b_write;
  assign mem_bus.wr_addr   = b_addr;
  assign mem_bus.wr_lane_n = b_lane_n;
  assign mem_bus.rd_addr   = a_addr;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign mem_bus.wr_word[i*LANE_W +: LANE_W] = {parity_lines_in[i], data_in[i*BYTE_W +: BYTE_W]};
    assign data_out[i*BYTE_W +: BYTE_W]        = out_word[i*LANE_W +: BYTE_W];
    assign parity_lines_out[i]                 = out_word[i*LANE_W + BYTE_W];
  end

  pbs_array u_array (
    .core_clk (core_clk),
    .mem      (mem_bus)
  );

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  always_comb begin
    next_out_valid = out_valid;
    if (!awake) begin
      next_out_valid = 1'b0;
    end else if (en) begin
      next_out_valid = a_valid && !a_write;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_word  <= '0;
    end else begin
      out_valid <= next_out_valid;
      if (en && a_valid && !a_write) begin
        out_word <= mem_bus.rd_word;
      end
    end
  end

  // Enable re-evaluated every clock even when stalled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_n         <= 1'b1;
      parity_lines_oe_n <= 1'b1;
    end else begin
      data_oe_n         <= !(next_out_valid && !output_enable_n);
      parity_lines_oe_n <= !(next_out_valid && !output_enable_n);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_STALL_HOLD: assert property (
    (clock_qualifier_n && awake && !sleep_request) |=>
      $stable(a_addr) && $stable(burst_beat) && $stable(out_word) && $stable(b_write))
    else $error("state changed on a stalled edge");

  AST_READ_LATENCY: assert property (
    (load && all_sel && write_enable_n && !sleep_request) ##1 (en && !sleep_request) |=> out_valid)
    else $error("read data not valid after next edge");

  AST_DRIVE_NEEDS_OE: assert property (
    !data_oe_n |-> $past(output_enable_n) == 1'b0 && out_valid)
    else $error("data driven without output enable");

  AST_DESELECT_FLOAT: assert property (
    (load && !all_sel && !sleep_request) ##1 (en && !sleep_request) |=> data_oe_n)
    else $error("outputs driven after pipelined deselect");

  AST_WRITE_FLOAT: assert property (
    (load && all_sel && !write_enable_n && !sleep_request) ##1 (en && !sleep_request)
      |=> data_oe_n && parity_lines_oe_n)
    else $error("outputs driven in write data phase");

  AST_WRITE_CAPTURE: assert property (
    (load && all_sel && !write_enable_n && !sleep_request) ##1 (en && !sleep_request) ##1 en
      |-> mem_bus.wr_en && mem_bus.wr_addr == $past(address, 2))
    else $error("write not captured on second edge");

  AST_BURST_STEP: assert property (
    (adv && burst_live) |=> burst_beat == $past(next_beat) && a_valid)
    else $error("burst counter did not advance");

  AST_BURST_TYPE: assert property (
    (adv && burst_live) |=> a_write == burst_write)
    else $error("access type changed within burst");

  AST_BURST_ORDER: assert property (
    (adv && burst_live && burst_order) |=>
      a_addr[BEAT_W-1:0] == ($past(burst_base[BEAT_W-1:0]) ^ $past(next_beat)))
    else $error("interleaved burst address wrong");

  AST_SLEEP_ENTRY: assert property (
    (awake && sleep_request) ##1 sleep_request |=> sleep_state == PBS_ASLEEP && data_oe_n)
    else $error("sleep not entered after two cycles");

  AST_POWER_UP: assert property (
    $rose(rst_n) |-> data_oe_n && !a_valid && !burst_live)
    else $error("not deselected after reset");

  AST_BURST_LINEAR: assert property (
    (adv && burst_live && !burst_order) |=>
      a_addr[BEAT_W-1:0] == BEAT_W'($past(burst_base[BEAT_W-1:0]) + $past(burst_beat) + BEAT_STEP))
    else $error("linear burst address wrong");

  AST_ADV_IDLE: assert property (
    (adv && !burst_live) |=> !a_valid)
    else $error("advance without a live burst started an access");

  AST_RESUME_FLOAT: assert property (
    (en && !a_valid) |=> data_oe_n && parity_lines_oe_n)
    else $error("outputs driven on first clock after deselect");

  AST_PENDING_DROP: assert property (
    !awake |=> !a_valid && !b_write && !out_valid && !burst_live)
    else $error("access kept across sleep entry");

  AST_SLEEP_EXIT: assert property (
    (sleep_state == PBS_ASLEEP && !sleep_request) ##1 !sleep_request |=> awake && !sleep_active)
    else $error("sleep not left after two cycles");

  COV_WRAP:  cover property (adv && burst_live && burst_beat == 2'h3);
  COV_READ:  cover property (load && all_sel && write_enable_n ##2 !data_oe_n);
  COV_WRITE: cover property (mem_bus.wr_en && mem_bus.wr_lane_n != '1);
  COV_BURST: cover property ((adv && burst_live)[*3]);
  COV_SLEEP: cover property (sleep_state == PBS_LEAVING ##1 awake);
endmodule : pbs_core

// ===== dv/pbs_ctrl_model.sv
// Purpose: Controller model for the burst SRAM core
// Assumes: One step call per rising edge of core_clk
// Notes:   Write data leaves two qualified steps after its command
`timescale 1ns/1ps
module pbs_ctrl_model
  import pbs_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Command
  output      logic              clock_qualifier_n,
  output      logic              chip_select_1_n,
  output      logic              chip_select_2,
  output      logic              chip_select_3_n,
  output      logic              advance_or_load,
  output      logic              write_enable_n,
  output      logic [LANES-1:0]  byte_lane_write_n,
  output      logic [ADDR_W-1:0] address,
  // Controls
  output      logic              output_enable_n,
  output      logic              sleep_request,
  // Write data
  output      logic [DATA_W-1:0] data_in,
  output      logic [LANES-1:0]  parity_lines_in
);
  // Pending write words, valid bit on top
  logic [WORD_W:0] wd1;
  logic [WORD_W:0] wd2;

  initial begin
    {clock_qualifier_n, chip_select_1_n, chip_select_2, chip_select_3_n} = 4'h4;
    {advance_or_load, write_enable_n, byte_lane_write_n} = 4'h7;
    {address, output_enable_n, sleep_request} = '0;
    {parity_lines_in, data_in} = '0;
    wd1 = '0;
    wd2 = '0;
  end

  // --------------------------------------------
  // One command per edge
  // --------------------------------------------
  task automatic step(input logic qn, input logic adv, input logic [2:0] cs, input logic we,
                      input logic [LANES-1:0] ln, input logic [ADDR_W-1:0] ad,
                      input logic [WORD_W:0] wd, input logic oe, input logic slp);
    @(posedge core_clk);
    clock_qualifier_n <= qn;
    {chip_select_1_n, chip_select_2, chip_select_3_n} <= cs;
    advance_or_load <= adv;
    write_enable_n <= we;
    byte_lane_write_n <= ln;
    address <= ad;
    output_enable_n <= oe;
    sleep_request <= slp;
    if (wd2[WORD_W])
      {parity_lines_in, data_in} <= wd2[WORD_W-1:0];
    else
      {parity_lines_in, data_in} <= ~{parity_lines_in, data_in};
    if (!qn) begin
      wd2 = wd1;
      wd1 = wd;
    end
  endtask : step
endmodule : pbs_ctrl_model

// ===== dv/pbs_core_test.sv
// Purpose: Self-checking bench for the burst SRAM core
// Assumes: Reads never hit a word written in the last three steps
// Notes:   Model tracks two qualified commands in flight
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module pbs_core_test;
  import pbs_pkg::*;
  typedef struct { int k; logic [ADDR_W-1:0] a; } pbs_cmd_t;

  logic core_clk, resetn, burst_order, bo, bact, bwr, prev_oe;
  logic clock_qualifier_n, chip_select_1_n, chip_select_2, chip_select_3_n, advance_or_load;
  logic write_enable_n, output_enable_n, sleep_request, data_oe_n, parity_lines_oe_n, sleep_active;
  logic [LANES-1:0]  byte_lane_write_n, parity_lines_in, parity_lines_out;
  logic [ADDR_W-1:0] address, ba, bst;
  logic [DATA_W-1:0] data_in, data_out;
  logic [WORD_W-1:0] mem [int];
  logic [ADDR_W-1:0] wa [8];
  int                n_mismatch, num_checks, beat;
  integer            seed;
  pbs_cmd_t          h1, h2;

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  pbs_ctrl_model ctrl (.core_clk, .clock_qualifier_n, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .advance_or_load, .write_enable_n, .byte_lane_write_n, .address,
    .output_enable_n, .sleep_request, .data_in, .parity_lines_in);
  pbs_core dut (.core_clk, .resetn, .clock_qualifier_n, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .advance_or_load, .write_enable_n, .byte_lane_write_n, .address,
    .burst_order, .output_enable_n, .sleep_request, .data_in, .parity_lines_in, .data_out,
    .data_oe_n, .parity_lines_out, .parity_lines_oe_n, .sleep_active);

  function automatic logic [WORD_W-1:0] rword();
    rword = WORD_W'($random(seed));
  endfunction : rword

  // --------------------------------------------
  // Drive one edge, update model, compare
  // --------------------------------------------
  task automatic go(input logic qn, input logic adv, input logic [2:0] cs, input logic we,
                    input logic [LANES-1:0] ln, input logic [ADDR_W-1:0] ad, input logic oe,
                    input logic slp);
    pbs_cmd_t          c;
    logic [WORD_W-1:0] wd;
    c.k = 0;
    c.a = ad;
    wd = rword();
    if (!qn && !adv) begin
      bact = (cs == 3'h2);
      bwr = !we;
      bst = ad;
      beat = 0;
    end else if (!qn && bact) begin
      beat++;
    end
    if (!qn) begin
      c.a = {bst[ADDR_W-1:2], bo ? bst[1:0] ^ beat[1:0] : bst[1:0] + beat[1:0]};
      c.k = !bact ? 3 : (bwr ? 2 : 1);
    end
    if (c.k == 2)
      for (int i = 0; i < LANES; i++) if (!ln[i]) begin
        mem[c.a][i*BYTE_W +: BYTE_W] = wd[i*BYTE_W +: BYTE_W];
        mem[c.a][DATA_W+i] = wd[DATA_W+i];
      end
    ctrl.step(qn, adv, cs, we, ln, ad, {c.k == 2, wd}, oe, slp);
    burst_order <= bo;
    #1;
    if (h2.k == 1 && !prev_oe) `CHK("read word", mem[h2.a], {parity_lines_out, data_out})
    if (h2.k != 0) `CHK("data drive", (h2.k == 1) ? prev_oe : 1'b1, data_oe_n)
    if (h2.k != 0) `CHK("parity drive", (h2.k == 1) ? prev_oe : 1'b1, parity_lines_oe_n)
    prev_oe = oe;
    if (!qn) begin
      h2 = h1;
      h1 = c;
    end
  endtask : go

  task automatic idle(input int n, input logic slp);
    // Third idle beat advances with no live burst
    for (int i = 0; i < n; i++)
      go(1'b0, (i % 3 == 2), (i % 3 == 0) ? 3'h6 : ((i % 3 == 1) ? 3'h0 : 3'h3), 1'b1, 2'h3, '0, 1'b0, slp);
  endtask : idle

  task automatic complete_run;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end

  // --------------------------------------------
  // Main sequence
  // --------------------------------------------
  initial begin
    {core_clk, resetn, bo, burst_order, bact, bwr, prev_oe} = '0;
    {n_mismatch, num_checks, beat, bst} = '0;
    seed = 32'h9816;
    h1 = '{0, '0};
    h2 = '{0, '0};
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("power-up drive", 1'b1, data_oe_n)
    for (int i = 0; i < 8; i++) begin
      wa[i] = rword();
      go(1'b0, 1'b0, 3'h2, 1'b0, 2'h0, wa[i], 1'b0, 1'b0);
    end
    idle(2, 1'b0);
    for (int i = 0; i < 8; i++) go(1'b0, 1'b0, 3'h2, 1'b1, 2'h3, wa[i], i[1], 1'b0);
    for (int i = 0; i < 3; i++) go(1'b0, 1'b0, 3'h2, 1'b0, 2'(i + 1), wa[i], 1'b0, 1'b0);
    idle(3, 1'b0);
    for (int i = 0; i < 3; i++) go(1'b0, 1'b0, 3'h2, 1'b1, 2'h3, wa[i], 1'b0, 1'b0);
    // Bursts in both orders from every start
    for (int o = 0; o < 2; o++) for (int s = 0; s < 4; s++) begin
      bo = o[0];
      ba = rword();
      ba[1:0] = s[1:0];
      go(1'b0, 1'b0, 3'h2, 1'b0, 2'h0, ba, 1'b0, 1'b0);
      repeat (3) go(1'b0, 1'b1, 3'(rword()), 1'(rword()), 2'h0, rword(), 1'b0, 1'b0);
      idle(3, 1'b0);
      go(1'b0, 1'b0, 3'h2, 1'b1, 2'h3, ba, 1'b0, 1'b0);
      // Fourth advance wraps back to the start word
      for (int j = 0; j < 4; j++) begin
        if (j == 1 && s[0]) go(1'b1, 1'b0, 3'h2, 1'b0, 2'h0, rword(), 1'b0, 1'b0);
        go(1'b0, 1'b1, 3'(rword()), 1'(rword()), 2'h3, rword(), 1'b0, 1'b0);
      end
      idle(2, 1'b0);
    end
    // Sleep only while deselected, contents kept
    idle(3, 1'b1);
    `CHK("sleep entered", 1'b1, sleep_active)
    idle(2, 1'b0);
    `CHK("sleep leaving", 1'b1, sleep_active)
    idle(1, 1'b0);
    `CHK("sleep left", 1'b0, sleep_active)
    idle(2, 1'b0);
    for (int i = 3; i < 6; i++) go(1'b0, 1'b0, 3'h2, 1'b1, 2'h3, wa[i], 1'b0, 1'b0);
    idle(3, 1'b0);
    complete_run();
  end
endmodule : pbs_core_test
